/* hdl/refresh_addr_counter.sv */
// refresh_addr_counter: refresh address, row bits lowest
// assumes increment is a one-cycle pulse from the sequencer; clear is a level decoded from the request pins
`timescale 1ns/1ps
`default_nettype none
module refresh_addr_counter #(
  parameter int unsigned W = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control: clear level, increment pulse
  input wire logic clear_i,
  input wire logic inc_i,
  // count value
  output logic [W-1:0] count_o
);
  // clear beats increment; all-ones wraps to zero
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count_o <= '0;
    end else if (inc_i) begin
      count_o <= count_o + W'(1);
    end
  end
endmodule
`default_nettype wire

/* hdl/refresh_ctrl.sv */
// refresh_ctrl: refresh request, arbitration and row strobe sequencer
// assumes pins arrive asynchronously and a classic wishbone master
// Behaviour
// - in-progress asserts one cycle before strobes
// - in-progress waits for access request negation
// - address counter increments after strobes negate
// - strobe low time from two bits
// - refresh clock period from four bits
// - refresh only between accesses, after precharge
// - auto refresh only while disable negated
// - request pulse latched, cleared at end
// - external refresh waits for access, precharge
// - held request runs another refresh cycle
// - pin becomes refresh request output
// - request output holds until refresh occurs
// - missed periods pulse request output high
// - exclusive types, precharge always guaranteed
// - conventional: all strobes assert together
// - conventional: all negate with in-progress
// - staggered single: one strobe per edge
// - staggered pair: two strobes per edge
// - staggered all: together, each meets low time
// - extend input lengthens strobe low time
// - extend sampled at end, all-strobe only
// - request with disable negated clears counter
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module refresh_ctrl
  import refresh_pkg::*;
#(
  parameter int unsigned ADDR_CNT_W = 24,
  parameter int unsigned ROW_W = 11
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // refresh pins, asynchronous
  input wire logic ext_refresh_req_n_i,
  input wire logic auto_refresh_disable_n_i,
  input wire logic refresh_extend_in_i,
  input wire logic port_a_access_request_n_i,
  input wire logic port_b_access_request_n_i,
  // memory side
  output logic [3:0] row_strobe_outputs_n_o,
  output logic refresh_in_progress_n_o,
  output logic [ROW_W-1:0] mem_addr_o
);
  // pin synchroniser stages; first stage read only by second
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic req_low; // external request asserted
  logic auto_en; // disable input negated
  logic extend; // extend input high
  logic access_busy; // either port running an access
  // configuration and fields
  logic [CFG_W-1:0] cfg;
  logic [1:0] low_bits;
  logic stagger;
  logic [2:0] scfg;
  logic [3:0] divider;
  logic refresh_in_progress_n_mode;
  // sequencer
  refresh_state_t state;
  refresh_state_t next_state;
  logic [3:0] cnt; // cycles since first strobe edge
  logic [3:0] low_time;
  logic [3:0] last_cnt;
  logic end_edge; // edge that would end the refresh
  logic may_extend;
  logic done; // strobes negate on this edge
  logic [1:0] prech_cnt; // precharge still owed
  // requests
  logic tick;
  logic ext_latch;
  logic auto_pend;
  logic refresh_request_out_n_pend;
  logic refresh_request_out_n_n;
  logic clear_cnt;
  logic [ADDR_CNT_W-1:0] addr_cnt;
  logic [3:0] strobe_low;

  // delay of strobe k behind the first strobe edge
  function automatic logic [3:0] stage_of(input int unsigned k, input logic stag,
                                          input logic [2:0] sc);
    if (!stag) begin
      stage_of = 4'h0;
    end else if (sc == SCFG_SINGLE) begin
      stage_of = 4'(k);
    end else if (sc == SCFG_PAIR) begin
      stage_of = 4'(k / 2);
    end else begin
      stage_of = 4'h0;
    end
  endfunction

  // two-flop synchroniser for all pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 5'h1b;
      sync2 <= 5'h1b;
    end else begin
      sync1 <= {port_b_access_request_n_i, port_a_access_request_n_i,
                refresh_extend_in_i, auto_refresh_disable_n_i, ext_refresh_req_n_i};
      sync2 <= sync1;
    end
  end

  // pin meanings
  assign req_low = !sync2[0];
  assign auto_en = sync2[1];
  assign extend = sync2[2];
  assign access_busy = !sync2[3] || !sync2[4];

  // configuration fields
  assign low_bits = cfg[CFG_LOW_LSB +: 2];
  assign stagger = cfg[CFG_STAG_BIT];
  assign scfg = cfg[CFG_SCFG_LSB +: 3];
  assign divider = cfg[CFG_DIV_LSB +: 4];
  assign refresh_in_progress_n_mode = cfg[CFG_CE0_BIT];

  // refresh timing figures
  assign low_time = LOW_TIME_BASE + {2'b00, low_bits};
  assign last_cnt = low_time - 4'h1 + stage_of(3, stagger, scfg);
  assign end_edge = (state == ST_STROBE) && (cnt == last_cnt);
  assign may_extend = !stagger || ((scfg != SCFG_SINGLE) && (scfg != SCFG_PAIR));
  assign done = end_edge && !(may_extend && extend);

  // wishbone: one wait state, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // configuration register, byte lanes 0 and 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= CFG_RESET;
    end else if (cyc_i && stb_i && we_i && !ack_o && (adr_i == CFG_OFS)) begin
      if (sel_i[0]) begin
        cfg[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        cfg[CFG_W-1:8] <= dat_i[CFG_W-1:8];
      end
    end
  end

  // read data; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_o) begin
      unique case (adr_i)
        CFG_OFS: dat_o <= 32'(cfg);
        STAT_OFS: dat_o <= {26'h0, refresh_request_out_n_pend, auto_pend, ext_latch, access_busy,
                            state == ST_STROBE, state != ST_IDLE};
        ADDR_OFS: dat_o <= 32'(addr_cnt);
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // internal refresh clock
  refresh_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(clear_cnt),
    .divider_i(divider),
    .tick_o(tick)
  );

  // request with disable negated clears counter and clock
  assign clear_cnt = req_low && auto_en;

  // refresh address counter
  refresh_addr_counter #(
    .W(ADDR_CNT_W)
  ) u_addr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(clear_cnt),
    .inc_i(done),
    .count_o(addr_cnt)
  );

  // external request latch; a held request sets it again at the end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_latch <= 1'b0;
    end else if (req_low) begin
      ext_latch <= 1'b1;
    end else if (done) begin
      ext_latch <= 1'b0;
    end
  end

  // automatic request, only while disable is negated
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_pend <= 1'b0;
    end else if (tick && auto_en) begin
      auto_pend <= 1'b1;
    end else if (done && !ext_latch) begin
      auto_pend <= 1'b0;
    end
  end

  // request output: holds until served, pulses high per missed period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refresh_request_out_n_pend <= 1'b0;
      refresh_request_out_n_n <= 1'b1;
    end else if (tick) begin
      refresh_request_out_n_pend <= 1'b1;
      refresh_request_out_n_n <= refresh_request_out_n_pend;
    end else if (done) begin
      refresh_request_out_n_pend <= 1'b0;
      refresh_request_out_n_n <= 1'b1;
    end else begin
      refresh_request_out_n_n <= !refresh_request_out_n_pend;
    end
  end

  // precharge owed after an access or a refresh
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prech_cnt <= 2'h0;
    end else if (access_busy || done) begin
      prech_cnt <= 2'(PRECHARGE_CYC);
    end else if (prech_cnt != 2'h0) begin
      prech_cnt <= prech_cnt - 2'h1;
    end
  end

  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        // never inside an access, never before precharge
        if ((ext_latch || auto_pend) && !access_busy && (prech_cnt == 2'h0)) begin
          next_state = ST_ANNOUNCE;
        end
      end
      ST_ANNOUNCE: begin
        next_state = ST_STROBE;
      end
      ST_STROBE: begin
        if (done) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // strobe cycle counter; frozen while extended
  always_ff @(posedge clk_i) begin
    if (rst_i || (state != ST_STROBE)) begin
      cnt <= 4'h0;
    end else if (!end_edge) begin
      cnt <= cnt + 4'h1;
    end
  end

  // per strobe window: own stage start, low time long
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_strobe
      always_comb begin
        strobe_low[k] = (state == ST_STROBE) && (cnt >= stage_of(k, stagger, scfg)) &&
                        (cnt < stage_of(k, stagger, scfg) + low_time);
      end
    end
  endgenerate

  // output pins
  assign row_strobe_outputs_n_o = ~strobe_low;
  assign refresh_in_progress_n_o = refresh_in_progress_n_mode ? (state == ST_IDLE) : refresh_request_out_n_n;
  assign mem_addr_o = addr_cnt[ROW_W-1:0];

  // helper: cycles strobe 0 has been low
  logic [7:0] low_len;
  always_ff @(posedge clk_i) begin
    if (rst_i || !strobe_low[0]) begin
      low_len <= 8'h00;
    end else begin
      low_len <= low_len + 8'h01;
    end
  end

  sequence seq_pair_stagger;
    (row_strobe_outputs_n_o == 4'b1100) ##1 (row_strobe_outputs_n_o == 4'b0000);
  endsequence
  // each strobe falls on its own edge; earlier ones may already have risen
  sequence seq_single_stagger;
    (row_strobe_outputs_n_o[3:1] == 3'b111 && !row_strobe_outputs_n_o[0])
      ##1 (row_strobe_outputs_n_o[3:2] == 2'b11 && !row_strobe_outputs_n_o[1])
      ##1 (row_strobe_outputs_n_o[3] && !row_strobe_outputs_n_o[2])
      ##1 !row_strobe_outputs_n_o[3];
  endsequence

  AST_ANNOUNCE_LEADS: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ST_ANNOUNCE) |-> (strobe_low == 4'h0) ##1 strobe_low[0])
    else $error("strobes not one cycle after announce");
  AST_NO_ACCESS_START: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == ST_ANNOUNCE) |-> !$past(access_busy) && ($past(prech_cnt) == 2'h0))
    else $error("refresh started during access or precharge");
  AST_COUNT_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    (done && !clear_cnt) |=> (addr_cnt == $past(addr_cnt) + ADDR_CNT_W'(1)))
    else $error("address counter did not step");
  AST_LOW_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(strobe_low[0]) |-> ($past(low_len) + 8'h01 >= 8'(low_time)))
    else $error("strobe low time too short");
  AST_LATCH_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    req_low |=> ext_latch)
    else $error("request pulse not latched");
  AST_BURST_AGAIN: assert property (@(posedge clk_i) disable iff (rst_i)
    (done && req_low) |=> ext_latch ##[1:8] (state == ST_ANNOUNCE) || access_busy)
    else $error("held request gave no further refresh");
  AST_MISSED_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && refresh_request_out_n_pend) |=> refresh_request_out_n_n ##1 (!refresh_request_out_n_n || !refresh_request_out_n_pend))
    else $error("missed period not pulsed");
  AST_CONV_ALL: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ST_ANNOUNCE && !stagger) |=> (row_strobe_outputs_n_o == 4'h0))
    else $error("conventional strobes not together");
  AST_SINGLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ST_ANNOUNCE && stagger && scfg == SCFG_SINGLE) |=> seq_single_stagger)
    else $error("single stagger order wrong");
  AST_PAIR: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ST_ANNOUNCE && stagger && scfg == SCFG_PAIR) |=> seq_pair_stagger)
    else $error("pair stagger order wrong");
  AST_EXTEND: assert property (@(posedge clk_i) disable iff (rst_i)
    (end_edge && may_extend && extend) |=> (state == ST_STROBE) && (strobe_low == 4'hf))
    else $error("extend did not hold strobes");
  AST_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_cnt |=> (addr_cnt == '0))
    else $error("counter not cleared");
endmodule
`default_nettype wire

/* hdl/refresh_timer.sv */
// refresh_timer: internal refresh clock, one tick per programmed period
// assumes divider bits are stable between refreshes; clear restarts the period
`timescale 1ns/1ps
`default_nettype none
module refresh_timer
  import refresh_pkg::*;
#(
  parameter int unsigned UNIT_CYC = REFRESH_UNIT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clear_i,
  input wire logic [3:0] divider_i,
  // one-cycle tick
  output logic tick_o
);
  // cycles within a unit, units within a period
  logic [9:0] unit_cnt;
  logic [3:0] unit_idx;
  logic unit_end;

  assign unit_end = (unit_cnt == 10'(UNIT_CYC - 1));

  // count units; a tick marks the end of the last unit
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      unit_cnt <= 10'h000;
      unit_idx <= 4'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (unit_end) begin
        unit_cnt <= 10'h000;
        if (unit_idx >= divider_i) begin
          unit_idx <= 4'h0;
          tick_o <= 1'b1;
        end else begin
          unit_idx <= unit_idx + 4'h1;
        end
      end else begin
        unit_cnt <= unit_cnt + 10'h001;
      end
    end
  end
endmodule
`default_nettype wire

/* shared/refresh_pkg.sv */
// refresh_pkg: constants, register map and types of the refresh control block
// assumes a 40 MHz system clock; shared by the controller and its helpers
package refresh_pkg;
  // clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 25000;
  // row strobe precharge, least time, rounded up to whole cycles
  localparam int unsigned PRECHARGE_NS = 50;
  localparam int unsigned PRECHARGE_CYC = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // refresh clock unit time; period is (divider + 1) units
  localparam int unsigned REFRESH_UNIT_NS = 1000;
  localparam int unsigned REFRESH_UNIT_CYC = (REFRESH_UNIT_NS * 1000) / CLK_PERIOD_PS;
  // strobe low time is low-time bits plus this many cycles
  localparam logic [3:0] LOW_TIME_BASE = 4'h2;
  // register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] ADDR_OFS = 8'h08;
  // configuration field positions
  localparam int unsigned CFG_LOW_LSB = 0;
  localparam int unsigned CFG_STAG_BIT = 2;
  localparam int unsigned CFG_SCFG_LSB = 3;
  localparam int unsigned CFG_DIV_LSB = 6;
  localparam int unsigned CFG_CE0_BIT = 10;
  localparam int unsigned CFG_W = 11;
  // configuration reset: all-strobe config, slowest clock, in-progress pin mode
  localparam logic [10:0] CFG_RESET = 11'h7d0;
  // strobe configuration codes
  localparam logic [2:0] SCFG_SINGLE = 3'h0;
  localparam logic [2:0] SCFG_PAIR = 3'h1;
  // refresh sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ANNOUNCE, ST_STROBE} refresh_state_t;
endpackage

/* test/refresh_partner.sv */
// refresh_partner: external refresh logic facing the refresh controller
// assumes the shared system clock and active-low pins that idle high
`timescale 1ns/1ps
`default_nettype none
module refresh_partner (
  // clock
  input wire logic clk_i,
  // commands from the bench
  input wire logic pulse_i,
  input wire logic burst_i,
  // controller outputs watched
  input wire logic refresh_in_progress_n_i,
  input wire logic mem_addr_out_bit7_i,
  // request pin, idles high
  output logic ext_refresh_req_n_o
);
  logic held; // burst still running
  initial begin
    held = 1'b0;
    ext_refresh_req_n_o = 1'b1;
  end
  // one-cycle pulse, or held low until 128 rows are done and refresh idles
  always @(posedge clk_i) begin
    if (burst_i) begin
      held <= 1'b1;
    end else if (mem_addr_out_bit7_i && refresh_in_progress_n_i) begin
      held <= 1'b0;
    end
    ext_refresh_req_n_o <= !(pulse_i || held || burst_i);
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
// testbench: random and corner refresh scenarios on the refresh controller
// assumes refresh_pkg, the controller and the partner model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module testbench;
  import refresh_pkg::*;
  // design and partner signals
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pulse, burst;
  logic [7:0] adr_i;
  logic [3:0] sel_i, strobes;
  logic [31:0] dat_i, dat_o, q;
  logic req_n, dis_n, ext_in, pa_n, pb_n, pin;
  logic [10:0] addr;
  int fails, n_tests, now, pin_fall, pin_rise, n_ref, n_end, gap_min, nr0, t0;
  int sfall [4];
  int slow [4];
  logic [3:0] ps;
  logic pp;
  refresh_ctrl refresh_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .ext_refresh_req_n_i(req_n),
    .auto_refresh_disable_n_i(dis_n), .refresh_extend_in_i(ext_in),
    .port_a_access_request_n_i(pa_n), .port_b_access_request_n_i(pb_n),
    .row_strobe_outputs_n_o(strobes), .refresh_in_progress_n_o(pin), .mem_addr_o(addr));
  refresh_partner refresh_partner_inst (.clk_i(clk_i), .pulse_i(pulse), .burst_i(burst),
    .refresh_in_progress_n_i(pin), .mem_addr_out_bit7_i(addr[7]),
    .ext_refresh_req_n_o(req_n));
  // clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // edge recorder: strobe and pin transitions in cycles
  always @(posedge clk_i) begin
    now++;
    for (int k = 0; k < 4; k++) begin
      if (ps[k] && !strobes[k]) sfall[k] = now;
      if (!ps[k] && strobes[k]) slow[k] = now - sfall[k];
    end
    if (pp && !pin) begin
      pin_fall = now;
      n_ref++;
      if (now - pin_rise < gap_min) gap_min = now - pin_rise;
    end
    if (!pp && pin) begin
      pin_rise = now;
      n_end++;
    end
    ps = strobes;
    pp = pin;
  end
  // verdict and end of run
  task close_out;
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // classic single wishbone cycle, waits for ack
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    `CHK(ack_o, 1'b1)
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task cfg(input logic [10:0] v);
    wb(1'b1, CFG_OFS, 4'h3, {21'h0, v});
  endtask
  task wait_pin(input logic lvl);
    int n;
    n = 0;
    while (pin !== lvl && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(pin, lvl)
  endtask
  // strobe start offset after the in-progress cycle
  function automatic int stage(input logic st, input logic [2:0] sc, input int k);
    if (!st) return 0;
    if (sc == SCFG_SINGLE) return k;
    if (sc == SCFG_PAIR) return k / 2;
    return 0;
  endfunction
  // one pulsed external refresh, optionally with extend held
  task one_ref(input logic [1:0] lt, input logic st, input logic [2:0] sc, input logic ex);
    logic [10:0] a0;
    int base;
    cfg({1'b1, 4'hf, sc, st, lt});
    a0 = addr;
    nr0 = n_ref;
    base = lt + LOW_TIME_BASE;
    pulse <= 1'b1;
    ext_in <= ex;
    @(posedge clk_i);
    pulse <= 1'b0;
    repeat (base + 6) @(posedge clk_i);
    ext_in <= 1'b0;
    repeat (20) @(posedge clk_i);
    `CHK(n_ref, nr0 + 1)
    for (int k = 0; k < 4; k++) begin
      `CHK(sfall[k] - pin_fall, 1 + stage(st, sc, k))
      if (ex && (!st || (sc != SCFG_SINGLE && sc != SCFG_PAIR))) `CHK(slow[k] > base, 1'b1)
      else `CHK(slow[k], base)
    end
    `CHK(pin_rise, sfall[3] + slow[3])
    `CHK(addr, a0 + 11'h1)
    wb(1'b0, ADDR_OFS, 4'hf, 32'h0);
    `CHK(q, {21'h0, a0 + 11'h1})
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    close_out();
  end
  // main sequence
  initial begin
    {cyc_i, stb_i, we_i, pulse, burst, dis_n, ext_in} = '0;
    {adr_i, sel_i, dat_i} = '0;
    {pa_n, pb_n, pp, rst_i} = 4'hf;
    ps = 4'hf;
    gap_min = 1000;
    void'($urandom(32'h5a627401));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(strobes, 4'hf)
    `CHK(pin, 1'b1)
    `CHK(addr, 11'h0)
    wb(1'b0, CFG_OFS, 4'hf, 32'h0);
    `CHK(q, {21'h0, CFG_RESET})
    wb(1'b1, CFG_OFS, 4'h1, 32'hffff_ff3f);
    wb(1'b1, 8'h40, 4'hf, 32'h0);
    wb(1'b0, 8'h40, 4'hf, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b0, CFG_OFS, 4'hf, 32'h0);
    `CHK(q, {21'h0, CFG_RESET[10:8], 8'h3f})
    for (int i = 0; i < 12; i++) begin
      one_ref(2'($urandom), (i / 3) % 2, (i % 3 == 2) ? 3'h5 : 3'(i % 3), i >= 6);
    end
    // access in progress on each port holds the refresh off
    for (int j = 0; j < 2; j++) begin
      cfg({1'b1, 4'hf, 3'h5, 1'b0, 2'h1});
      nr0 = n_ref;
      if (j == 0) pa_n <= 1'b0;
      else pb_n <= 1'b0;
      pulse <= 1'b1;
      @(posedge clk_i);
      pulse <= 1'b0;
      repeat (8 + $urandom % 16) @(posedge clk_i);
      `CHK(n_ref, nr0)
      wb(1'b0, STAT_OFS, 4'hf, 32'h0);
      `CHK(q[4:0], 5'h0c)
      pa_n <= 1'b1;
      pb_n <= 1'b1;
      t0 = now;
      repeat (20) @(posedge clk_i);
      `CHK(n_ref, nr0 + 1)
      `CHK(pin_fall - t0 >= PRECHARGE_CYC + 4, 1'b1)
    end
    // automatic refresh at the programmed period, none when disabled
    t0 = $urandom % 4;
    dis_n <= 1'b1;
    cfg({1'b1, 4'(t0), 3'h5, 1'b0, 2'h0});
    nr0 = n_ref;
    repeat ((t0 + 1) * 400) @(posedge clk_i);
    `CHK((n_ref - nr0) >= 9 && (n_ref - nr0) <= 11, 1'b1)
    dis_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    nr0 = n_ref;
    repeat (300) @(posedge clk_i);
    `CHK(n_ref, nr0)
    // counter clear, then a held burst across 128 rows
    dis_n <= 1'b1;
    burst <= 1'b1;
    gap_min = 1000;
    repeat (3) @(posedge clk_i);
    dis_n <= 1'b0;
    nr0 = n_end;
    repeat (5) @(posedge clk_i);
    burst <= 1'b0;
    t0 = 0;
    while (addr[7] !== 1'b1 && t0 < 3000) begin
      @(posedge clk_i);
      t0++;
    end
    // let the recorder see the last rise first
    @(posedge clk_i);
    `CHK(n_end - nr0, 128)
    `CHK(gap_min, PRECHARGE_CYC + 1)
    repeat (30) @(posedge clk_i);
    // request output mode
    cfg({1'b0, 4'h0, 3'h5, 1'b0, 2'h0});
    wait_pin(1'b0);
    nr0 = sfall[0];
    repeat (30) @(posedge clk_i);
    `CHK(sfall[0], nr0)
    `CHK(strobes, 4'hf)
    wait_pin(1'b1);
    @(posedge clk_i);
    `CHK(pin, 1'b0)
    t0 = sfall[0];
    pulse <= 1'b1;
    @(posedge clk_i);
    pulse <= 1'b0;
    repeat (15) @(posedge clk_i);
    `CHK(sfall[0] > t0, 1'b1)
    `CHK(pin, 1'b1)
    close_out();
  end
endmodule
`default_nettype wire
